// File: hdl/dlce_top.sv
// What this block does
// - Each luma sample is multiplied by a six-bit contrast value.
// - Contrast gain is setting divided by 32, so 32 gives unity.
// - Separate main and side contrast values; the current picture's one applies.
// - Minimum and maximum of low-pass-filtered luma are measured each field.
// - Tilt point is minimum plus ratio coefficient times measured span.
// - Below tilt, output is input plus amount times input minus tilt.
// - No expansion for samples above the programmable ceiling threshold.
// - Half-rate colour-difference pairs are interpolated up to full pixel rate.
// - Luma and colour difference go to RGB through a programmable matrix.
// - A five-bit OSD code per pixel can replace the video colour.
// - OSD sampling and display clock phase restart at each horizontal flyback.
// - Each colour channel leaves as a ten-bit converter word.
// - Priority code picks main or side contrast and matrix values.
// - Priority code enables or disables the expander per pixel.
`timescale 1ns/1ns
`default_nettype none

module dlce_top #(
  parameter int LP_SHIFT = 2
) (
  input  wire logic                                 clk_in,
  input  wire logic                                 srst_in,
  input  wire logic                                 pix_valid_in,
  input  wire logic [dlce_pkg::Y_IN_W-1:0]          luma_in,
  input  wire logic [dlce_pkg::C_W-1:0]             chroma_in,
  input  wire logic                                 hflyback_in,
  input  wire logic                                 field_start_in,
  input  wire logic [dlce_pkg::OSD_W-1:0]           osd_code_in,
  input  wire logic [dlce_pkg::PRIO_W-1:0]          prio_in,
  input  wire logic [dlce_pkg::NPRIO-1:0]           prio_side_map_in,
  input  wire logic [dlce_pkg::NPRIO-1:0]           prio_osd_map_in,
  input  wire logic [dlce_pkg::NPRIO-1:0]           prio_expander_map_in,
  input  wire logic [dlce_pkg::CON_W-1:0]           contrast_main_in,
  input  wire logic [dlce_pkg::CON_W-1:0]           contrast_side_in,
  input  wire logic [dlce_pkg::COEF_W-1:0]          tilt_ratio_coeff_in,
  input  wire logic [dlce_pkg::COEF_W-1:0]          expansion_amount_coeff_in,
  input  wire logic [dlce_pkg::Y_W-1:0]             expansion_ceiling_threshold_in,
  input  wire dlce_pkg::dlce_mtx_t                  matrix_main_in,
  input  wire dlce_pkg::dlce_mtx_t                  matrix_side_in,
  input  wire logic                                 osd_wr_en_in,
  input  wire logic [3:0]                           osd_wr_addr_in,
  input  wire logic [dlce_pkg::OSD_RGB_W-1:0]       osd_wr_data_in,
  output logic                                      rgb_valid_out,
  output dlce_pkg::dlce_rgb_t                       rgb_out,
  output logic                                      disp_clk_out,
  output logic [dlce_pkg::Y_W-1:0]                  meas_min_out,
  output logic [dlce_pkg::Y_W-1:0]                  meas_max_out
);

  dlce_pkg::dlce_pix_t                   pipe_q [dlce_pkg::PIPE_DEPTH];
  logic                                  phase_q;
  logic [dlce_pkg::C_W-1:0]              chroma_q;
  logic signed [dlce_pkg::C_W-1:0]       cb_hold_q;
  dlce_pkg::dlce_chroma_t                pair_cur_q;
  dlce_pkg::dlce_chroma_t                pair_prev_q;
  dlce_pkg::dlce_chroma_t                chroma_full_q;
  logic [dlce_pkg::Y_W-1:0]              lp_q;
  logic [dlce_pkg::Y_W-1:0]              run_min_q;
  logic [dlce_pkg::Y_W-1:0]              run_max_q;
  logic [dlce_pkg::Y_W-1:0]              tilt_q;
  dlce_pkg::dlce_rgb_t                   mtx_rgb_q;
  logic [dlce_pkg::OSD_RGB_W-1:0]        osd_ram [dlce_pkg::OSD_RAM_WORDS];

  logic [14:0]                           con_prod;
  logic [dlce_pkg::Y_W-1:0]              con_y_d;
  logic [10:0]                           lp_sum;
  logic [dlce_pkg::Y_W-1:0]              lp_d;
  logic [dlce_pkg::Y_W-1:0]              span;
  logic [14:0]                           tilt_prod;
  logic [9:0]                            tilt_sum;
  logic [dlce_pkg::Y_W-1:0]              tilt_d;
  logic                                  expand;
  logic [dlce_pkg::Y_W-1:0]              exp_diff;
  logic [14:0]                           exp_prod;
  logic [dlce_pkg::Y_W-1:0]              exp_y_d;
  logic signed [dlce_pkg::C_W-1:0]       chroma_s;
  logic signed [dlce_pkg::C_W:0]         cb_avg;
  logic signed [dlce_pkg::C_W:0]         cr_avg;
  dlce_pkg::dlce_chroma_t                chroma_full_d;
  dlce_pkg::dlce_mtx_t                   mtx;
  dlce_pkg::dlce_rgb_t                   osd_rgb;
  logic [3:0]                            osd_ram_addr;

  function automatic logic [dlce_pkg::DAC_W-1:0] sat_dac(input logic signed [13:0] v);
    if (v < 0) begin
      return '0;
    end else if (v > $signed({4'h0, dlce_pkg::DAC_MAX})) begin
      return dlce_pkg::DAC_MAX;
    end else begin
      return v[dlce_pkg::DAC_W-1:0];
    end
  endfunction

  function automatic logic [dlce_pkg::DAC_W-1:0] mtx_chan(
    input logic [dlce_pkg::Y_W-1:0]          y,
    input logic signed [dlce_pkg::MTX_W-1:0] k1,
    input logic signed [dlce_pkg::MTX_W-1:0] k2,
    input dlce_pkg::dlce_chroma_t            c
  );
    logic signed [17:0] mac;
    logic signed [13:0] sum;
    mac = 18'(k1) * 18'(c.cb) + 18'(k2) * 18'(c.cr);
    sum = $signed({4'h0, y, 1'b0}) + 14'(mac >>> dlce_pkg::MTX_SHIFT);
    return sat_dac(sum);
  endfunction

  function automatic logic [dlce_pkg::DAC_W-1:0] osd_expand(input logic [3:0] c);
    return {c, c, c[3:2]};
  endfunction

  // Pixel phase and display clock restart on every flyback so the insertion phase is fixed.
  always_ff @(posedge clk_in) begin
    if (srst_in || hflyback_in) begin
      phase_q      <= 1'b0;
      disp_clk_out <= 1'b0;
    end else begin
      disp_clk_out <= ~disp_clk_out;
      if (pix_valid_in) begin
        phase_q <= ~phase_q;
      end
    end
  end

  // Input stage: priority decode and OSD code are captured with the pixel.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pipe_q[0] <= '0;
      chroma_q  <= dlce_pkg::CHROMA_OFFSET;
    end else begin
      pipe_q[0].valid   <= pix_valid_in;
      pipe_q[0].odd     <= phase_q;
      pipe_q[0].side    <= prio_side_map_in[prio_in];
      pipe_q[0].ble_en  <= prio_expander_map_in[prio_in];
      pipe_q[0].osd_sel <= prio_osd_map_in[prio_in];
      pipe_q[0].osd     <= osd_code_in;
      pipe_q[0].y       <= {1'b0, luma_in};
      chroma_q          <= chroma_in;
    end
  end

  // Contrast multiply with saturation.
  always_comb begin
    con_prod = pipe_q[0].y * (pipe_q[0].side ? contrast_side_in : contrast_main_in);
    if (con_prod[14:dlce_pkg::CON_SHIFT] > {1'b0, dlce_pkg::Y_MAX}) begin
      con_y_d = dlce_pkg::Y_MAX;
    end else begin
      con_y_d = con_prod[13:dlce_pkg::CON_SHIFT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pipe_q[1] <= '0;
    end else begin
      pipe_q[1]   <= pipe_q[0];
      pipe_q[1].y <= con_y_d;
    end
  end

  // Low-pass filter and per-field min and max measurement.
  always_comb begin
    lp_sum = {2'b00, lp_q} + {1'b0, lp_q, 1'b0} + {2'b00, pipe_q[1].y};
    lp_d   = 9'(lp_sum >> LP_SHIFT);
    if (meas_max_out <= meas_min_out) begin
      span = '0;
    end else begin
      span = meas_max_out - meas_min_out;
    end
    tilt_prod = span * tilt_ratio_coeff_in;
    tilt_sum  = {1'b0, meas_min_out} + {1'b0, tilt_prod[14:dlce_pkg::RATIO_SHIFT]};
    tilt_d    = tilt_sum[9] ? dlce_pkg::Y_MAX : tilt_sum[8:0];
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lp_q         <= '0;
      run_min_q    <= dlce_pkg::RUN_MIN_RESET;
      run_max_q    <= dlce_pkg::RUN_MAX_RESET;
      meas_min_out <= '0;
      meas_max_out <= '0;
      tilt_q       <= '0;
    end else begin
      tilt_q <= tilt_d;
      if (pipe_q[1].valid) begin
        lp_q <= lp_d;
      end
      if (field_start_in) begin
        meas_min_out <= run_min_q;
        meas_max_out <= run_max_q;
        run_min_q    <= dlce_pkg::RUN_MIN_RESET;
        run_max_q    <= dlce_pkg::RUN_MAX_RESET;
      end else if (pipe_q[1].valid) begin
        if (lp_d < run_min_q) begin
          run_min_q <= lp_d;
        end
        if (lp_d > run_max_q) begin
          run_max_q <= lp_d;
        end
      end
    end
  end

  // Black level expander.
  always_comb begin
    expand   = pipe_q[1].ble_en && (pipe_q[1].y < tilt_q) &&
               (pipe_q[1].y <= expansion_ceiling_threshold_in);
    exp_diff = tilt_q - pipe_q[1].y;
    exp_prod = exp_diff * expansion_amount_coeff_in;
    if (!expand) begin
      exp_y_d = pipe_q[1].y;
    end else if ({2'b00, pipe_q[1].y} > exp_prod[14:dlce_pkg::AMT_SHIFT]) begin
      exp_y_d = 9'(({2'b00, pipe_q[1].y}) - exp_prod[14:dlce_pkg::AMT_SHIFT]);
    end else begin
      exp_y_d = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pipe_q[2] <= '0;
    end else begin
      pipe_q[2]   <= pipe_q[1];
      pipe_q[2].y <= exp_y_d;
    end
  end

  // Luma waits here so it meets the interpolated chroma of the same pixel.
  for (genvar i = 3; i < dlce_pkg::PIPE_DEPTH; i++) begin : g_delay
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        pipe_q[i] <= '0;
      end else begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  // Chroma pairing: Cb on even pixels, Cr on odd pixels.
  assign chroma_s = $signed(chroma_q ^ dlce_pkg::CHROMA_OFFSET);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cb_hold_q   <= '0;
      pair_cur_q  <= '0;
      pair_prev_q <= '0;
    end else if (pipe_q[0].valid) begin
      if (!pipe_q[0].odd) begin
        cb_hold_q <= chroma_s;
      end else begin
        pair_prev_q <= pair_cur_q;
        pair_cur_q  <= '{cb: cb_hold_q, cr: chroma_s};
      end
    end
  end

  // Co-sited pixels take the pair, in-between pixels take the average of two pairs.
  always_comb begin
    cb_avg = {pair_prev_q.cb[7], pair_prev_q.cb} + {pair_cur_q.cb[7], pair_cur_q.cb};
    cr_avg = {pair_prev_q.cr[7], pair_prev_q.cr} + {pair_cur_q.cr[7], pair_cur_q.cr};
    if (pipe_q[4].odd) begin
      chroma_full_d.cb = cb_avg[8:1];
      chroma_full_d.cr = cr_avg[8:1];
    end else begin
      chroma_full_d = pair_prev_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chroma_full_q <= '0;
    end else begin
      chroma_full_q <= chroma_full_d;
    end
  end

  // Matrix to RGB, aligned with pipe stage five.
  assign mtx = pipe_q[5].side ? matrix_side_in : matrix_main_in;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mtx_rgb_q <= '0;
    end else begin
      mtx_rgb_q.r <= mtx_chan(pipe_q[5].y, mtx.r1, mtx.r2, chroma_full_q);
      mtx_rgb_q.g <= mtx_chan(pipe_q[5].y, mtx.g1, mtx.g2, chroma_full_q);
      mtx_rgb_q.b <= mtx_chan(pipe_q[5].y, mtx.b1, mtx.b2, chroma_full_q);
    end
  end

  // OSD colour table: fixed lower half, writable upper half.
  always_ff @(posedge clk_in) begin
    if (osd_wr_en_in) begin
      osd_ram[osd_wr_addr_in] <= osd_wr_data_in;
    end
  end

  assign osd_ram_addr = pipe_q[6].osd[3:0];

  always_comb begin
    if (pipe_q[6].osd[4]) begin
      osd_rgb.r = osd_expand(osd_ram[osd_ram_addr][11:8]);
      osd_rgb.g = osd_expand(osd_ram[osd_ram_addr][7:4]);
      osd_rgb.b = osd_expand(osd_ram[osd_ram_addr][3:0]);
    end else begin
      osd_rgb.r = pipe_q[6].osd[0] ? (pipe_q[6].osd[3] ? dlce_pkg::OSD_HALF_LEVEL
                                                        : dlce_pkg::OSD_FULL_LEVEL) : '0;
      osd_rgb.g = pipe_q[6].osd[1] ? (pipe_q[6].osd[3] ? dlce_pkg::OSD_HALF_LEVEL
                                                        : dlce_pkg::OSD_FULL_LEVEL) : '0;
      osd_rgb.b = pipe_q[6].osd[2] ? (pipe_q[6].osd[3] ? dlce_pkg::OSD_HALF_LEVEL
                                                        : dlce_pkg::OSD_FULL_LEVEL) : '0;
    end
  end

  // Output words to the converters.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rgb_valid_out <= 1'b0;
      rgb_out       <= '0;
    end else begin
      rgb_valid_out <= pipe_q[6].valid;
      rgb_out       <= pipe_q[6].osd_sel ? osd_rgb : mtx_rgb_q;
    end
  end

endmodule

`default_nettype wire

// File: include/dlce_pkg.sv
package dlce_pkg;

  localparam int Y_IN_W      = 8;
  localparam int C_W         = 8;
  localparam int Y_W         = 9;
  localparam int DAC_W       = 10;
  localparam int CON_W       = 6;
  localparam int CON_UNITY   = 32;
  localparam int CON_SHIFT   = 5;
  localparam int COEF_W      = 6;
  localparam int RATIO_SHIFT = 6;
  localparam int AMT_SHIFT   = 4;
  localparam int MTX_W       = 9;
  localparam int MTX_SHIFT   = 6;
  localparam int OSD_W       = 5;
  localparam int PRIO_W      = 3;
  localparam int NPRIO       = 8;
  localparam int OSD_RAM_WORDS = 16;
  localparam int OSD_RGB_W   = 12;
  localparam int PIPE_DEPTH  = 7;
  localparam int FULL_RATE_KHZ = 20250;
  localparam int CLK_KHZ     = 125000;

  localparam logic [Y_W-1:0]   Y_MAX          = 9'h1ff;
  localparam logic [Y_W-1:0]   RUN_MIN_RESET  = 9'h1ff;
  localparam logic [Y_W-1:0]   RUN_MAX_RESET  = 9'h000;
  localparam logic [C_W-1:0]   CHROMA_OFFSET  = 8'h80;
  localparam logic [DAC_W-1:0] DAC_MAX        = 10'h3ff;
  localparam logic [DAC_W-1:0] OSD_FULL_LEVEL = 10'h3ff;
  localparam logic [DAC_W-1:0] OSD_HALF_LEVEL = 10'h1ff;

  typedef struct packed {
    logic signed [MTX_W-1:0] r1;
    logic signed [MTX_W-1:0] r2;
    logic signed [MTX_W-1:0] g1;
    logic signed [MTX_W-1:0] g2;
    logic signed [MTX_W-1:0] b1;
    logic signed [MTX_W-1:0] b2;
  } dlce_mtx_t;

  typedef struct packed {
    logic [DAC_W-1:0] r;
    logic [DAC_W-1:0] g;
    logic [DAC_W-1:0] b;
  } dlce_rgb_t;

  typedef struct packed {
    logic signed [C_W-1:0] cb;
    logic signed [C_W-1:0] cr;
  } dlce_chroma_t;

  typedef struct packed {
    logic             valid;
    logic             odd;
    logic             side;
    logic             ble_en;
    logic             osd_sel;
    logic [OSD_W-1:0] osd;
    logic [Y_W-1:0]   y;
  } dlce_pix_t;

endpackage

// File: bench/dlce_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dlce_top_assertions (
  input wire logic                        clk_in,
  input wire logic                        srst_in,
  input wire logic                        pix_valid_in,
  input wire logic                        hflyback_in,
  input wire logic                        field_start_in,
  input wire logic [dlce_pkg::OSD_W-1:0]  osd_code_in,
  input wire logic [dlce_pkg::PRIO_W-1:0] prio_in,
  input wire logic [dlce_pkg::NPRIO-1:0]  prio_osd_map_in,
  input wire logic                        rgb_valid_out,
  input wire dlce_pkg::dlce_rgb_t         rgb_out,
  input wire logic                        disp_clk_out,
  input wire logic [dlce_pkg::Y_W-1:0]    meas_min_out,
  input wire logic [dlce_pkg::Y_W-1:0]    meas_max_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire logic osd_px = pix_valid_in && prio_osd_map_in[prio_in];
  AST_PIPE_VALID: assert property (pix_valid_in |-> ##8 rgb_valid_out)
    else $error("output missing eight cycles after a pixel");
  AST_PIPE_IDLE: assert property (!pix_valid_in |-> ##8 !rgb_valid_out)
    else $error("output valid without a pixel");
  AST_OSD_FULL: assert property (osd_px && osd_code_in == 5'h07
    |-> ##8 rgb_out == {3{dlce_pkg::OSD_FULL_LEVEL}}) else $error("osd white wrong");
  AST_OSD_HALF: assert property (osd_px && osd_code_in == 5'h0f
    |-> ##8 rgb_out == {3{dlce_pkg::OSD_HALF_LEVEL}}) else $error("osd half white wrong");
  AST_OSD_BLACK: assert property (osd_px && osd_code_in == 5'h08
    |-> ##8 rgb_out == 30'h0) else $error("osd black wrong");
  AST_DCLK_FLYBACK: assert property (hflyback_in |=> !disp_clk_out)
    else $error("display clock runs in flyback");
  AST_DCLK_RUN: assert property (!hflyback_in && !$past(hflyback_in) && !$past(srst_in)
    |=> disp_clk_out != $past(disp_clk_out)) else $error("display clock stalled");
  AST_MEAS_HOLD: assert property (!field_start_in [*3]
    |=> $stable(meas_min_out) && $stable(meas_max_out)) else $error("measure moved in field");
  COV_OSD: cover property (osd_px ##8 rgb_valid_out);
  COV_FIELD: cover property (field_start_in);
  COV_LINE: cover property (hflyback_in ##1 !hflyback_in ##1 pix_valid_in);
endmodule
bind dlce_top dlce_top_assertions u_chk (.clk_in, .srst_in, .pix_valid_in, .hflyback_in,
  .field_start_in, .osd_code_in, .prio_in, .prio_osd_map_in, .rgb_valid_out, .rgb_out,
  .disp_clk_out, .meas_min_out, .meas_max_out);
`default_nettype wire

// File: bench/dlce_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module dlce_src_model (
  input  wire logic       clk_in,
  output logic            pix_valid_out,
  output logic [7:0]      luma_out,
  output logic [7:0]      chroma_out,
  output logic            hflyback_out
);
  initial begin
    pix_valid_out = 1'b0;
    luma_out = 8'h00;
    chroma_out = 8'h80;
    hflyback_out = 1'b0;
  end
  // Sends a flyback, then an even count of back to back pixels, Cb first.
  task automatic send_line(input logic [7:0] ya, input logic [7:0] yb,
                           input logic [7:0] cr, input int n);
    repeat (2) begin
      @(posedge clk_in);
      hflyback_out <= 1'b1;
      pix_valid_out <= 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      hflyback_out <= 1'b0;
      pix_valid_out <= 1'b1;
      luma_out <= i[0] ? yb : ya;
      chroma_out <= i[0] ? cr : 8'h80;
    end
    @(posedge clk_in);
    pix_valid_out <= 1'b0;
    luma_out <= ~luma_out;
    chroma_out <= ~chroma_out;
  endtask
endmodule
`default_nettype wire

// File: bench/dlce_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module dlce_top_tb;
  logic                clk_in = 1'b0;
  logic                srst_in = 1'b1;
  logic                fs = 1'b0;
  logic                wr_en = 1'b0;
  logic [2:0]          prio = 3'h0;
  logic [4:0]          osd_code = 5'h00;
  logic [5:0]          con_m = 6'h20;
  logic [5:0]          con_s = 6'h10;
  logic [8:0]          ceil_th = 9'h1ff;
  logic [3:0]          wr_addr = 4'h0;
  logic [11:0]         wr_data = 12'h000;
  dlce_pkg::dlce_mtx_t mtx_m = '0;
  dlce_pkg::dlce_mtx_t mtx_s = '0;
  logic                pv, hfb, rv, dclk;
  logic [7:0]          luma, chroma;
  dlce_pkg::dlce_rgb_t rgb, a, b, c;
  logic [8:0]          mmin, mmax;
  int                  mismatches = 0;
  int                  checks_done = 0;
  always #4 clk_in = ~clk_in;
  dlce_src_model src (.clk_in(clk_in), .pix_valid_out(pv), .luma_out(luma),
    .chroma_out(chroma), .hflyback_out(hfb));
  dlce_top dut (.clk_in(clk_in), .srst_in(srst_in), .pix_valid_in(pv), .luma_in(luma),
    .chroma_in(chroma), .hflyback_in(hfb), .field_start_in(fs), .osd_code_in(osd_code),
    .prio_in(prio), .prio_side_map_in(8'h02), .prio_osd_map_in(8'h04),
    .prio_expander_map_in(8'h08), .contrast_main_in(con_m), .contrast_side_in(con_s),
    .tilt_ratio_coeff_in(6'h3f), .expansion_amount_coeff_in(6'h3f),
    .expansion_ceiling_threshold_in(ceil_th), .matrix_main_in(mtx_m),
    .matrix_side_in(mtx_s), .osd_wr_en_in(wr_en), .osd_wr_addr_in(wr_addr),
    .osd_wr_data_in(wr_data), .rgb_valid_out(rv), .rgb_out(rgb), .disp_clk_out(dclk),
    .meas_min_out(mmin), .meas_max_out(mmax));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Sends one line and returns the sixth output word, clear of the line edges.
  task automatic px(input logic [7:0] y, input logic [7:0] cr, input logic [2:0] p,
                    input logic [4:0] oc, output dlce_pkg::dlce_rgb_t r);
    int k;
    k = 0;
    r = '0;
    for (int t = 0; t < 30 && rv !== 1'b0; t++) begin
      @(posedge clk_in);
      #1;
    end
    if (rv !== 1'b0) begin
      mismatches++;
      finish_test();
    end
    @(posedge clk_in);
    prio <= p;
    osd_code <= oc;
    fork
      src.send_line(y, y, cr, 12);
      for (int t = 0; t < 60 && k < 6; t++) begin
        @(posedge clk_in);
        #1;
        if (rv === 1'b1) begin
          k++;
          if (k == 6) r = rgb;
        end
      end
    join
    if (k < 6) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic t_contrast();
    logic d0;
    px(8'h40, 8'h80, 3'h0, 5'h00, a);
    px(8'h40, 8'h80, 3'h1, 5'h00, b);
    `CHK(a.r > 10'h0, 1'b1)
    `CHK(a.r, 10'h080)
    `CHK(a.r, a.g)
    `CHK({b.r, 1'b0}, {1'b0, a.r})
    @(posedge clk_in);
    con_m <= 6'h00;
    px(8'h40, 8'h80, 3'h0, 5'h00, c);
    `CHK(c, 30'h0)
    @(posedge clk_in);
    con_m <= 6'h3f;
    con_s <= 6'h20;
    px(8'h40, 8'h80, 3'h0, 5'h00, c);
    px(8'h40, 8'h80, 3'h1, 5'h00, b);
    `CHK(c.r > b.r, 1'b1)
    @(posedge clk_in);
    #1;
    d0 = dclk;
    @(posedge clk_in);
    #1;
    `CHK(dclk, ~d0)
    $display("test contrast done");
  endtask
  task automatic t_matrix();
    @(posedge clk_in);
    con_m <= 6'h20;
    mtx_m <= {9'h000, 9'h040, 36'h0};
    mtx_s <= {27'h0, 9'h040, 18'h0};
    px(8'h40, 8'ha0, 3'h0, 5'h00, a);
    px(8'h40, 8'ha0, 3'h1, 5'h00, b);
    `CHK(a.r - a.g, 10'h020)
    `CHK(b.g - b.b, 10'h020)
    `CHK(b.r, b.b)
    @(posedge clk_in);
    con_m <= 6'h3f;
    px(8'hff, 8'hff, 3'h0, 5'h00, a);
    px(8'h00, 8'h00, 3'h0, 5'h00, b);
    `CHK(a.r, 10'h3ff)
    `CHK(b.r, 10'h000)
    $display("test matrix done");
  endtask
  task automatic t_osd();
    logic [9:0] lv;
    for (int i = 0; i < 16; i++) begin
      lv = i[3] ? dlce_pkg::OSD_HALF_LEVEL : dlce_pkg::OSD_FULL_LEVEL;
      px(8'h40, 8'h80, 3'h2, i[4:0], a);
      `CHK(a, {i[0] ? lv : 10'h0, i[1] ? lv : 10'h0, i[2] ? lv : 10'h0})
    end
    @(posedge clk_in);
    wr_en <= 1'b1;
    wr_addr <= 4'h3;
    wr_data <= 12'h5a3;
    @(posedge clk_in);
    wr_en <= 1'b0;
    px(8'h40, 8'h80, 3'h2, 5'h13, a);
    `CHK(a, {10'h155, 10'h2aa, 10'h0cc})
    $display("test osd done");
  endtask
  task automatic t_expander();
    @(posedge clk_in);
    con_m <= 6'h20;
    mtx_m <= '0;
    fs <= 1'b1;
    @(posedge clk_in);
    fs <= 1'b0;
    src.send_line(8'h10, 8'hf0, 8'h80, 24);
    @(posedge clk_in);
    fs <= 1'b1;
    @(posedge clk_in);
    fs <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK(mmax > mmin, 1'b1)
    px(8'h10, 8'h80, 3'h0, 5'h00, a);
    px(8'h10, 8'h80, 3'h3, 5'h00, b);
    `CHK(b.r < a.r, 1'b1)
    px(8'hf0, 8'h80, 3'h0, 5'h00, a);
    px(8'hf0, 8'h80, 3'h3, 5'h00, c);
    `CHK(c, a)
    @(posedge clk_in);
    ceil_th <= 9'h000;
    px(8'h10, 8'h80, 3'h0, 5'h00, a);
    px(8'h10, 8'h80, 3'h3, 5'h00, b);
    `CHK(b, a)
    $display("test expander done");
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    t_contrast();
    t_matrix();
    t_osd();
    t_expander();
    finish_test();
  end
endmodule
`default_nettype wire
